// >>> sag_params.svh
// constants for the setpoint access guard: offsets, fields, resets, timing
`ifndef SAG_PARAMS_SVH
`define SAG_PARAMS_SVH

// ==========================================================================
// register offsets (byte addresses, one word each)
`define SAG_ADDR_STATUS   6'h00
`define SAG_ADDR_EVENTS   6'h04
`define SAG_ADDR_MASK     6'h08
`define SAG_ADDR_FP_LOCK  6'h0C
`define SAG_ADDR_CHAR     6'h10
`define SAG_ADDR_ENTER    6'h14
`define SAG_ADDR_CODE_SET 6'h18
`define SAG_ADDR_SETTING  6'h1C
`define SAG_ADDR_INSTALL  6'h20

// ==========================================================================
// field positions
`define SAG_ST_JUMPER     4
`define SAG_ST_ZERO       5
`define SAG_ST_READY      6
`define SAG_EV_JUMPER_REJ 0
`define SAG_EV_LOCK_REJ   1
`define SAG_EV_BAD_CODE   2
`define SAG_EV_TIMEOUT    3
`define SAG_CHAR_POS_LSB  8

// ==========================================================================
// reset values and code limits
`define SAG_CODE_CHARS    4'h8
`define SAG_ZERO_CHAR     8'h30
`define SAG_RST_CODE      64'h0000_0000_0000_0030
`define SAG_RST_CODE_LEN  4'h1
`define SAG_RST_SETTING   32'h0000_0000
`define SAG_RST_MASK      4'h0

// ==========================================================================
// timing: clock period, idle tick, inactivity limit
`define SAG_CLK_NS        8
`define SAG_TICK_NS       1000000
`define SAG_IDLE_MIN      30
`define SAG_TICK_CYC      (`SAG_TICK_NS / `SAG_CLK_NS)
`define SAG_IDLE_TICKS    (`SAG_IDLE_MIN * 60 * 1000)

`endif

// >>> sag_pkg.sv
// types shared by the setpoint access guard
package sag_pkg;

  // ========================================================================
  // interfaces that can write settings
  typedef enum logic [1:0] {
    SAG_SRC_PANEL   = 2'h0,
    SAG_SRC_PROGRAM = 2'h1,
    SAG_SRC_REAR_A  = 2'h2,
    SAG_SRC_REAR_B  = 2'h3
  } sag_src_t;

  typedef logic [63:0] sag_code_t;

endpackage : sag_pkg

// >>> sag_entry_mem.sv
// per-interface staging memory for passcode characters, registered read
module sag_entry_mem
  import sag_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [1:0]    wr_addr,
  input  wire logic [2:0]    wr_pos,
  input  wire logic [7:0]    wr_char,
  input  wire logic [1:0]    rd_addr,
  output sag_pkg::sag_code_t rd_data
);
  import sag_pkg::*;

  sag_code_t mem [0:3];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr][wr_pos*8 +: 8] <= wr_char;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : sag_entry_mem

// >>> sag_idle_timer.sv
// inactivity timer for one interface, counts idle ticks while armed
`include "sag_params.svh"
module sag_idle_timer
  import sag_pkg::*;
#(
  parameter int unsigned IDLE_TICKS = `SAG_IDLE_TICKS
)
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic tick,
  input  wire logic restart,
  input  wire logic armed,
  output logic      expire
);
  import sag_pkg::*;

  logic [20:0] cnt_q;
  logic        at_end;

  assign at_end = (cnt_q == 21'(IDLE_TICKS - 1));
  assign expire = armed && tick && at_end && !restart;

  // a locked interface holds the count at zero, so relock is fresh
  always_ff @(posedge clk) begin
    if (!nrst || !armed || restart || expire) begin
      cnt_q <= 21'h0;
    end else if (tick) begin
      cnt_q <= cnt_q + 21'h1;
    end
  end

endmodule : sag_idle_timer

// >>> sag_guard.sv
// setpoint access guard: jumper, passcode, per-interface unlock, idle relock
//
// The register addresses and strobed register access were chosen for this implementation.
`include "sag_params.svh"

// Overview of operation
// - panel setting writes need the jumper
// - jumperless panel write rejected, error raised
// - jumper ignored for serial port writes
// - stores passcode of up to eight characters
// - passcode resets to zero
// - zero passcode lifts all passcode locks
// - nonzero passcode blocks locked interfaces
// - matching passcode entry unlocks that interface
// - each interface has its own unlock
// - panel lock command relocks front panel
// - wrong passcode relocks that port
// - thirty idle minutes relock an interface
// - not ready: warning shown, relay de-energised
// - same setting path for every source
// - jumper removal relocks front panel
module sag_guard
  import sag_pkg::*;
#(
  parameter int unsigned TICK_CYC   = `SAG_TICK_CYC,
  parameter int unsigned IDLE_TICKS = `SAG_IDLE_TICKS
)
(
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic [5:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  sag_pkg::sag_src_t SRC,
  output logic [31:0]      RDATA,
  input  wire logic        KEY_PRESS,
  input  wire logic        ACCESS_JUMPER,
  output logic             IRQ,
  output logic             ACCESS_ERR,
  output logic             NOT_READY_WARN,
  output logic             SELFTEST_RELAY
);
  import sag_pkg::*;

  // ========================================================================
  // functions
  function automatic logic code_match(sag_code_t a, logic [3:0] alen,
                                      sag_code_t b, logic [3:0] blen);
    logic ok;
    ok = (alen == blen);
    for (int i = 0; i < 8; i++) begin
      if (i < alen && a[i*8 +: 8] != b[i*8 +: 8]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : code_match

  function automatic logic [3:0] src_hot(logic [1:0] s);
    return 4'h1 << s;
  endfunction : src_hot

  // ========================================================================
  // state
  logic [2:0]  jsync_q;
  logic        jump_q;
  logic [3:0]  unlock_q;
  logic [3:0]  unlock_d;
  sag_code_t   code_q;
  logic [3:0]  code_len_q;
  logic [31:0] setting_q;
  logic        ready_q;
  logic [3:0]  events_q;
  logic [3:0]  events_d;
  logic [3:0]  mask_q;
  logic        enter_q;
  logic        cset_q;
  logic [1:0]  pend_src_q;
  logic [3:0]  pend_len_q;
  logic [16:0] div_q;
  logic        tick;
  sag_code_t   entry;
  logic [3:0]  expire;
  logic [31:0] rdata_q;

  // ========================================================================
  // decode
  wire wr_char    = WR && ADDR == `SAG_ADDR_CHAR;
  wire wr_enter   = WR && ADDR == `SAG_ADDR_ENTER;
  wire wr_cset    = WR && ADDR == `SAG_ADDR_CODE_SET;
  wire wr_setting = WR && ADDR == `SAG_ADDR_SETTING;
  wire wr_install = WR && ADDR == `SAG_ADDR_INSTALL;
  wire wr_events  = WR && ADDR == `SAG_ADDR_EVENTS;
  wire wr_mask    = WR && ADDR == `SAG_ADDR_MASK;
  wire wr_fp_lock = WR && ADDR == `SAG_ADDR_FP_LOCK
                    && SRC == SAG_SRC_PANEL;
  wire is_guarded = wr_setting || wr_install || wr_cset;

  wire code_zero  = code_len_q == `SAG_RST_CODE_LEN
                    && code_q[7:0] == `SAG_ZERO_CHAR;
  wire src_panel  = SRC == SAG_SRC_PANEL;
  wire pass_ok    = code_zero || unlock_q[SRC];
  wire jump_ok    = !src_panel || jump_q;
  wire write_ok   = pass_ok && jump_ok;
  wire rej_jumper = is_guarded && src_panel && !jump_q;
  wire rej_lock   = is_guarded && jump_ok && !pass_ok;
  wire enter_hit  = code_match(code_q, code_len_q, entry, pend_len_q);
  wire enter_good = enter_q && enter_hit;
  wire enter_bad  = enter_q && !enter_hit;
  wire new_len_ok = WDATA[3:0] != 4'h0 && WDATA[3:0] <= `SAG_CODE_CHARS;
  wire [3:0] act  = ({4{WR || RD}} & src_hot(SRC))
                    | {3'h0, KEY_PRESS};

  // ========================================================================
  // jumper pin: three stages, change taken when the last two agree
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      jsync_q <= 3'h0;
      jump_q  <= 1'b0;
    end else begin
      jsync_q <= {jsync_q[1:0], ACCESS_JUMPER};
      if (jsync_q[1] == jsync_q[2]) begin
        jump_q <= jsync_q[2];
      end
    end
  end

  // ========================================================================
  // staged passcode characters, one slot per interface
  sag_entry_mem u_entry (
    .clk     (REF_CLK),
    .wr_en   (wr_char),
    .wr_addr (SRC),
    .wr_pos  (WDATA[`SAG_CHAR_POS_LSB +: 3]),
    .wr_char (WDATA[7:0]),
    .rd_addr (SRC),
    .rd_data (entry)
  );

  // ========================================================================
  // idle tick divider and per-interface timers
  assign tick = div_q == 17'(TICK_CYC - 1);

  always_ff @(posedge REF_CLK) begin
    if (!NRST || tick) begin
      div_q <= 17'h0;
    end else begin
      div_q <= div_q + 17'h1;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_tmr
    sag_idle_timer #(.IDLE_TICKS(IDLE_TICKS)) u_tmr (
      .clk     (REF_CLK),
      .nrst    (NRST),
      .tick    (tick),
      .restart (act[g]),
      .armed   (unlock_q[g] && !code_zero),
      .expire  (expire[g])
    );
  end

  // ========================================================================
  // unlock state, one bit per interface
  wire [3:0] pend_hot = src_hot(pend_src_q);
  wire [3:0] lock_set = {4{enter_good}} & pend_hot;
  wire [3:0] lock_clr = ({4{enter_bad}} & pend_hot)
                        | expire
                        | {3'h0, wr_fp_lock};

  // an entry changes only the entering interface; jumper loss forces panel locked
  assign unlock_d = ((unlock_q & ~lock_clr) | lock_set)
                    & {3'h7, jump_q};

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      unlock_q <= 4'h0;
    end else begin
      unlock_q <= unlock_d;
    end
  end

  // ========================================================================
  // entry and code-set commands wait one cycle for the staged characters
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      enter_q    <= 1'b0;
      cset_q     <= 1'b0;
      pend_src_q <= 2'h0;
      pend_len_q <= 4'h0;
    end else begin
      enter_q    <= wr_enter;
      cset_q     <= wr_cset && write_ok && new_len_ok;
      pend_src_q <= SRC;
      pend_len_q <= WDATA[3:0];
    end
  end

  // ========================================================================
  // stored passcode and settings, same path whatever the source
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      code_q     <= `SAG_RST_CODE;
      code_len_q <= `SAG_RST_CODE_LEN;
      setting_q  <= `SAG_RST_SETTING;
      ready_q    <= 1'b0;
    end else begin
      if (cset_q) begin
        code_q     <= entry;
        code_len_q <= pend_len_q;
      end
      if (wr_setting && write_ok) begin
        setting_q <= WDATA;
      end
      if (wr_install && write_ok) begin
        ready_q <= WDATA[0];
      end
    end
  end

  // ========================================================================
  // sticky events, write one to clear, a new event beats the clear
  assign events_d = {expire != 4'h0, enter_bad, rej_lock, rej_jumper};

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      events_q <= 4'h0;
      mask_q   <= `SAG_RST_MASK;
    end else begin
      events_q <= (events_q & ~({4{wr_events}} & WDATA[3:0])) | events_d;
      if (wr_mask) begin
        mask_q <= WDATA[3:0];
      end
    end
  end

  assign IRQ        = (events_q & mask_q) != 4'h0;
  assign ACCESS_ERR = events_q[`SAG_EV_JUMPER_REJ];

  // not ready keeps the self-test relay dropped so a blank unit is noticed
  assign NOT_READY_WARN = !ready_q;
  assign SELFTEST_RELAY = ready_q;

  // ========================================================================
  // read port: data one cycle after the strobe, zero when unmapped
  wire [31:0] status_w = {25'h0, ready_q, code_zero, jump_q, unlock_q};
  wire [31:0] rd_mux =
      ADDR == `SAG_ADDR_STATUS  ? status_w :
      ADDR == `SAG_ADDR_EVENTS  ? {28'h0, events_q} :
      ADDR == `SAG_ADDR_MASK    ? {28'h0, mask_q} :
      ADDR == `SAG_ADDR_SETTING ? setting_q :
      ADDR == `SAG_ADDR_INSTALL ? {31'h0, ready_q} : 32'h0;

  always_ff @(posedge REF_CLK) begin
    if (!NRST || !RD) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  assign RDATA = rdata_q;

  // ========================================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  sequence enter_s;
    wr_enter ##1 enter_q;
  endsequence

  sequence bad_enter_s;
    enter_s ##0 !enter_hit;
  endsequence

  panel_jumper_a: assert property (
    wr_setting && src_panel && !jump_q |=> $stable(setting_q))
    else $error("panel write taken without jumper");

  panel_reject_a: assert property (
    wr_setting && src_panel && !jump_q |=> events_q[0] && ACCESS_ERR)
    else $error("jumperless panel write not flagged");

  serial_jumper_a: assert property (
    wr_setting && !src_panel && code_zero |=> setting_q == $past(WDATA))
    else $error("serial write blocked with zero code");

  reset_code_a: assert property (
    $rose(NRST) |-> code_zero)
    else $error("passcode not zero after reset");

  locked_block_a: assert property (
    wr_setting && !code_zero && !unlock_q[SRC] |=> $stable(setting_q))
    else $error("locked interface changed a setting");

  unlock_good_a: assert property (
    enter_s ##0 enter_hit && (pend_src_q != 2'h0 || jump_q)
    |=> unlock_q[$past(pend_src_q)])
    else $error("matching code did not unlock");

  unlock_only_a: assert property (
    enter_q |=> (unlock_q & ~$past(unlock_q) & ~$past(pend_hot)) == 4'h0)
    else $error("another interface got unlocked");

  fp_lock_a: assert property (
    wr_fp_lock |=> !unlock_q[0])
    else $error("panel lock command ignored");

  bad_code_a: assert property (
    bad_enter_s |=> !unlock_q[$past(pend_src_q)] ##0 events_q[2])
    else $error("wrong code left port unlocked");

  not_ready_a: assert property (
    !ready_q |-> NOT_READY_WARN && !SELFTEST_RELAY)
    else $error("not ready but relay energised");

  jumper_off_a: assert property (
    $fell(jump_q) |=> !unlock_q[0] [*2])
    else $error("panel still unlocked after jumper loss");

endmodule : sag_guard

// >>> sag_host_model.sv
// host model: keypad and serial hosts driving the register port
`include "sag_params.svh"
module sag_host_model (
  input  wire logic         clk,
  input  wire logic [31:0]  rdata,
  output logic [5:0]        addr,
  output logic [31:0]       wdata,
  output logic              wr,
  output logic              rd,
  output sag_pkg::sag_src_t src,
  output logic              key
);
  timeunit 1ns;
  timeprecision 1ps;
  import sag_pkg::*;

  // ==========================================================================
  // idle bus at time zero
  initial begin
    addr = 6'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    src = SAG_SRC_PANEL;
    key = 1'b0;
  end

  // ==========================================================================
  // bus cycles: one-cycle strobes, a free cycle before the next
  task automatic wr_reg(input sag_src_t s, input logic [5:0] a,
                        input logic [31:0] d);
    @(posedge clk);
    src <= s;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input sag_src_t s, input logic [5:0] a,
                        output logic [31:0] d);
    @(posedge clk);
    src <= s;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // passcode is staged then entered; a wrong one relocks the port
  task automatic send_code(input sag_src_t s, input logic [63:0] c,
                           input logic [3:0] n, input logic [5:0] a);
    for (int i = 0; i < n; i++) begin
      wr_reg(s, `SAG_ADDR_CHAR, {21'h0, i[2:0], c[8*i+:8]});
    end
    wr_reg(s, a, {28'h0, n});
    repeat (2) @(posedge clk);
    #1;
  endtask : send_code

  task automatic press();
    @(posedge clk);
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
  endtask : press
endmodule : sag_host_model

// >>> tb_sag_guard.sv
// self-checking bench for the setpoint access guard
`include "sag_params.svh"
module tb_sag_guard;
  timeunit 1ns;
  timeprecision 1ps;
  import sag_pkg::*;

  // ==========================================================================
  // nets and bench state
  localparam logic [5:0] A_ST  = `SAG_ADDR_STATUS;
  localparam logic [5:0] A_EV  = `SAG_ADDR_EVENTS;
  localparam logic [5:0] A_MK  = `SAG_ADDR_MASK;
  localparam logic [5:0] A_EN  = `SAG_ADDR_ENTER;
  localparam logic [5:0] A_SET = `SAG_ADDR_SETTING;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        jmp = 1'b1;
  logic [5:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  sag_src_t    src;
  logic        key;
  logic        irq;
  logic        aerr;
  logic        nrw;
  logic        relay;
  logic [31:0] seed = 32'h9C73;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  // short counts keep the idle relock near twenty cycles
  sag_guard #(.TICK_CYC(4), .IDLE_TICKS(5)) dut (
    .REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .SRC(src), .RDATA(rdata), .KEY_PRESS(key),
    .ACCESS_JUMPER(jmp), .IRQ(irq), .ACCESS_ERR(aerr),
    .NOT_READY_WARN(nrw), .SELFTEST_RELAY(relay));

  sag_host_model host (
    .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .src(src), .key(key));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] stat(logic [3:0] u, logic j, logic z,
                                       logic r);
    return {25'h0, r, z, j, u};
  endfunction : stat

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic chk_rd(input sag_src_t s, input logic [5:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    host.rd_reg(s, a, d);
    check(d, e);
  endtask : chk_rd

  task automatic note(input string name);
    $display("test %s done", name);
  endtask : note

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] setv;
    logic [63:0] code;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check(32'({nrw, relay, irq, aerr}), 32'h8);
    repeat (6) @(posedge clk);
    chk_rd(SAG_SRC_PANEL, A_ST, stat(4'h0, 1'b1, 1'b1, 1'b0));
    chk_rd(SAG_SRC_PANEL, 6'h3C, 32'h0);
    note("reset");
    // zero code: every source writes the same setting path
    for (int i = 0; i < 4; i++) begin
      setv = rnd();
      host.wr_reg(sag_src_t'(i), A_SET, setv);
      chk_rd(SAG_SRC_REAR_B, A_SET, setv);
    end
    host.wr_reg(SAG_SRC_REAR_B, `SAG_ADDR_INSTALL, 32'h1);
    check(32'({nrw, relay}), 32'h1);
    note("zero_code");
    // jumper gone: panel refused, serial still allowed
    @(posedge clk);
    jmp <= 1'b0;
    repeat (6) @(posedge clk);
    host.wr_reg(SAG_SRC_PANEL, A_SET, rnd());
    check(32'(aerr), 32'h1);
    chk_rd(SAG_SRC_PANEL, A_SET, setv);
    setv = rnd();
    host.wr_reg(SAG_SRC_REAR_A, A_SET, setv);
    chk_rd(SAG_SRC_REAR_A, A_SET, setv);
    host.wr_reg(SAG_SRC_PANEL, A_MK, 32'h1);
    check(32'(irq), 32'h1);
    chk_rd(SAG_SRC_PANEL, A_EV, 32'h1);
    host.wr_reg(SAG_SRC_PANEL, A_EV, 32'h1);
    check(32'({irq, aerr}), 32'h0);
    @(posedge clk);
    jmp <= 1'b1;
    repeat (6) @(posedge clk);
    note("jumper");
    // eight character code locks every port
    code = {rnd(), rnd()};
    host.send_code(SAG_SRC_PROGRAM, code, 4'h8, `SAG_ADDR_CODE_SET);
    chk_rd(SAG_SRC_REAR_A, A_ST, stat(4'h0, 1'b1, 1'b0, 1'b1));
    host.wr_reg(SAG_SRC_REAR_A, A_SET, rnd());
    chk_rd(SAG_SRC_REAR_A, A_SET, setv);
    chk_rd(SAG_SRC_REAR_A, A_EV, 32'h2);
    check(32'(irq), 32'h0);
    host.wr_reg(SAG_SRC_REAR_A, A_EV, 32'hF);
    note("lock");
    // short prefix and one wrong character do not match
    host.send_code(SAG_SRC_REAR_B, code, 4'h7, A_EN);
    chk_rd(SAG_SRC_REAR_B, A_ST, stat(4'h0, 1'b1, 1'b0, 1'b1));
    host.send_code(SAG_SRC_REAR_B, code ^ 64'h1, 4'h8, A_EN);
    chk_rd(SAG_SRC_REAR_B, A_ST, stat(4'h0, 1'b1, 1'b0, 1'b1));
    // unlocking one port leaves the others locked
    host.send_code(SAG_SRC_REAR_A, code, 4'h8, A_EN);
    chk_rd(SAG_SRC_REAR_A, A_ST, stat(4'h4, 1'b1, 1'b0, 1'b1));
    setv = rnd();
    host.wr_reg(SAG_SRC_REAR_A, A_SET, setv);
    host.wr_reg(SAG_SRC_REAR_B, A_SET, rnd());
    chk_rd(SAG_SRC_REAR_A, A_SET, setv);
    host.send_code(SAG_SRC_REAR_A, ~code, 4'h8, A_EN);
    chk_rd(SAG_SRC_REAR_A, A_ST, stat(4'h0, 1'b1, 1'b0, 1'b1));
    chk_rd(SAG_SRC_REAR_A, A_EV, 32'h6);
    host.wr_reg(SAG_SRC_REAR_A, A_EV, 32'hF);
    note("unlock");
    // panel relocks by command and by losing the jumper
    host.send_code(SAG_SRC_PANEL, code, 4'h8, A_EN);
    chk_rd(SAG_SRC_PANEL, A_ST, stat(4'h1, 1'b1, 1'b0, 1'b1));
    host.wr_reg(SAG_SRC_PANEL, `SAG_ADDR_FP_LOCK, 32'h0);
    chk_rd(SAG_SRC_PANEL, A_ST, stat(4'h0, 1'b1, 1'b0, 1'b1));
    host.send_code(SAG_SRC_PANEL, code, 4'h8, A_EN);
    @(posedge clk);
    jmp <= 1'b0;
    repeat (8) @(posedge clk);
    chk_rd(SAG_SRC_PANEL, A_ST, stat(4'h0, 1'b0, 1'b0, 1'b1));
    @(posedge clk);
    jmp <= 1'b1;
    repeat (6) @(posedge clk);
    note("panel");
    // keypresses keep the panel open while the idle port relocks
    host.send_code(SAG_SRC_PROGRAM, code, 4'h8, A_EN);
    host.send_code(SAG_SRC_PANEL, code, 4'h8, A_EN);
    for (int i = 0; i < 6; i++) begin
      host.press();
      repeat (6) @(posedge clk);
    end
    chk_rd(SAG_SRC_PANEL, A_ST, stat(4'h1, 1'b1, 1'b0, 1'b1));
    chk_rd(SAG_SRC_PANEL, A_EV, 32'h8);
    host.wr_reg(SAG_SRC_PANEL, A_MK, 32'hF);
    chk_rd(SAG_SRC_PANEL, A_MK, 32'hF);
    check(32'(irq), 32'h1);
    host.wr_reg(SAG_SRC_PANEL, A_EV, 32'hF);
    check(32'(irq), 32'h0);
    note("idle");
    // second reset in mid-run: code back to zero, unlocks and ready gone
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(32'({nrw, relay, irq, aerr}), 32'h8);
    // a zero length code set is ignored, the code stays zero
    host.send_code(SAG_SRC_REAR_A, code, 4'h0, `SAG_ADDR_CODE_SET);
    chk_rd(SAG_SRC_REAR_A, A_ST, stat(4'h0, 1'b1, 1'b1, 1'b0));
    chk_rd(SAG_SRC_REAR_A, `SAG_ADDR_INSTALL, 32'h0);
    note("reset_again");
    end_of_test();
  end
endmodule : tb_sag_guard
